//--- logic/brc_pkg.sv
// Package of constants and types for the external bus release control block.
package brc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] BRC_CTRL_ADDR = 16'hFF1B;
    localparam logic [7:0] BRC_CTRL_RESET = 8'hFE;
    localparam logic [6:0] BRC_RSVD_ONES = 7'h7F;
    localparam logic [7:0] BRC_UNMAPPED_DATA = 8'h00;
    localparam int BRC_EN_BIT = 0;
    localparam int BRC_PIN_ACK = 1;
    localparam int BRC_PIN_REQ = 0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BRC_OWNED = 4'h1,
        BRC_RELEASED = 4'h2,
        BRC_RECLAIM = 4'h4,
        BRC_RESUME = 4'h8
    } brc_phase_t;

    // Status of the CPU bus sequencer for the current state (one state per clock).
    typedef struct packed {
        logic twoState;
        logic threeState;
        logic internalOp;
        logic mulDiv;
        logic stateT1;
        logic stateT2;
        logic stateT3;
        logic stateTw;
        logic cycleEnd;
        logic upperByte;
        logic sleep;
    } brc_seq_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } brc_reg_req_t;

    typedef struct packed {
        brc_phase_t phase;
        logic pend;
        logic ackN;
        logic enable;
        logic [7:0] rdata;
    } brc_state_t;

    localparam brc_state_t BRC_STATE_RESET = '{
        phase: BRC_OWNED,
        pend: 1'b0,
        ackN: 1'b1,
        enable: BRC_CTRL_RESET[BRC_EN_BIT],
        rdata: BRC_UNMAPPED_DATA
    };

endpackage

//--- logic/brc_release_ctrl.sv
// Bus release control: request sampling, grant, bus float and control register.
//
// Operation
// - Control register loads FE on reset and in hardware standby.
// - Software standby leaves the control register untouched.
// - Control bits 7 to 1 are read-only and read as one.
// - Enable 0 gives port pins 6 and 5 to GPIO; 1 gives grant and request.
// - Request sampled in fetch and data cycles; low releases at cycle end.
// - No release between upper and lower byte of a split word access; the multiply-divide and sleep terms still release there.
// - During multiply or divide, release at the end of a machine cycle.
// - In sleep mode a low request is granted at once.
// - Two-state access: sample at first state, grant low after second.
// - Three-state access: sample at first, second, wait; grant after third.
// - Internal operation: sample at first state, grant low after it.
// - Released: address, data and all strobes go high impedance.
// - Released state samples request every cycle; stays while low.
// - Request high while released: grant goes high after the next state.
// - CPU cycles resume one state after the grant returns high.
// - No interrupt is accepted while the bus is released.
// - Reset pin low resets everything except in hardware standby.
// - Wait states may sit between second and third states of a slow access.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
module brc_release_ctrl
    import brc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic resetPin_n,
    input wire logic hwStandby,
    input wire brc_seq_t seq,
    input wire brc_reg_req_t regReq,
    output logic [7:0] regRdata,
    input wire logic [1:0] gpioOut,
    input wire logic [1:0] gpioDrive,
    output logic [1:0] gpioIn,
    input wire logic portA6In,
    output logic portA6Out,
    output logic portA6Oe_n,
    input wire logic portA5In,
    output logic portA5Out,
    output logic portA5Oe_n,
    output logic busOe_n,
    output logic cpuHold,
    output logic intBlock,
    output logic grantActive
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    brc_state_t r_q;
    brc_state_t r_d;
    brc_state_t rIn_q;
    logic [1:0] gpioIn_q;
    logic busRequest;
    logic samplePoint;
    logic goRelease;
    logic ctrlHit;
    logic wipe;

    function automatic logic hitCtrl(input logic [15:0] a);
        hitCtrl = (a == BRC_CTRL_ADDR);
    endfunction

    // ------------------------------------------------------------
    // Request sampling
    // ------------------------------------------------------------
    // A disabled block never sees a request, so it can never release.
    assign busRequest = r_q.enable && !portA5In;
    // The three-state access also samples during wait states.
    assign samplePoint = ((seq.twoState || seq.internalOp) && seq.stateT1) ||
                         (seq.threeState && (seq.stateT1 || seq.stateT2 || seq.stateTw));
    // The upper byte of a split word ends in a release only through the multiply-divide or sleep term.
    assign goRelease = (seq.cycleEnd && !seq.upperByte && (r_q.pend || (samplePoint && busRequest))) ||
                       (seq.mulDiv && seq.cycleEnd && busRequest) ||
                       (seq.sleep && busRequest);
    assign ctrlHit = hitCtrl(regReq.addr);
    // Reset pin is ignored in hardware standby, but standby itself clears the register.
    assign wipe = !rst_n || hwStandby || !resetPin_n;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.rdata = BRC_UNMAPPED_DATA;
        if (regReq.rd) begin
            r_d.rdata = ctrlHit ? {BRC_RSVD_ONES, r_q.enable} : BRC_UNMAPPED_DATA;
        end
        if (regReq.wr && ctrlHit) begin
            r_d.enable = regReq.wdata[BRC_EN_BIT];
        end
        case (r_q.phase)
            BRC_OWNED: begin
                // The request is latched so a master that keeps it low is served at cycle end.
                r_d.pend = r_q.enable && (r_q.pend || (samplePoint && busRequest));
                if (r_q.enable && goRelease) begin
                    r_d.phase = BRC_RELEASED;
                    r_d.ackN = 1'b0;
                    r_d.pend = 1'b0;
                end
            end
            BRC_RELEASED: begin
                if (!busRequest) begin
                    r_d.phase = BRC_RECLAIM;
                end
            end
            BRC_RECLAIM: begin
                r_d.ackN = 1'b1;
                r_d.phase = BRC_RESUME;
            end
            BRC_RESUME: begin
                r_d.phase = BRC_OWNED;
            end
            default: begin
                r_d = BRC_STATE_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Software standby has no input here, so the register simply holds through it.
    always_ff @(posedge clk) begin
        if (wipe) begin
            r_q <= BRC_STATE_RESET;
            gpioIn_q <= 2'h0;
        end else begin
            r_q <= r_d;
            gpioIn_q <= {portA6In, portA5In};
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regRdata = r_q.rdata;
    assign gpioIn = gpioIn_q;
    // Pin 6 carries the grant only when enabled; otherwise the port owns it.
    assign portA6Out = r_q.enable ? r_q.ackN : gpioOut[BRC_PIN_ACK];
    assign portA6Oe_n = r_q.enable ? 1'b0 : !gpioDrive[BRC_PIN_ACK];
    assign portA5Out = gpioOut[BRC_PIN_REQ];
    assign portA5Oe_n = r_q.enable ? 1'b1 : !gpioDrive[BRC_PIN_REQ];
    assign busOe_n = !r_q.ackN;
    assign cpuHold = (r_q.phase != BRC_OWNED);
    assign intBlock = (r_q.phase != BRC_OWNED);
    assign grantActive = !r_q.ackN;
    assign rIn_q = r_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence sTwoSample;
        r_q.phase == BRC_OWNED && r_q.enable && seq.twoState && seq.stateT1 && busRequest && !seq.sleep;
    endsequence

    sequence sTwoEnd;
        seq.twoState && seq.stateT2 && seq.cycleEnd && !seq.upperByte && !hwStandby && resetPin_n;
    endsequence

    sequence sThreeEnd;
        seq.threeState && seq.stateT3 && seq.cycleEnd && !seq.upperByte && !hwStandby && resetPin_n;
    endsequence

    a_standby_reset: assert property ($past(hwStandby) |-> !r_q.enable && r_q.ackN)
        else $error("control register not reset by hardware standby");

    a_reserved_ones: assert property ($past(regReq.rd && ctrlHit) && $past(resetPin_n && !hwStandby)
        |-> regRdata[7:1] == BRC_RSVD_ONES)
        else $error("reserved control bits did not read as one");

    a_write_enable: assert property (regReq.wr && ctrlHit && resetPin_n && !hwStandby
        |=> r_q.enable == $past(regReq.wdata[BRC_EN_BIT]))
        else $error("enable bit did not take the written value");

    a_gpio_when_off: assert property (!r_q.enable |-> portA6Oe_n == !gpioDrive[BRC_PIN_ACK]
        && portA6Out == gpioOut[BRC_PIN_ACK])
        else $error("port pin 6 not given to GPIO while disabled");

    a_never_grant_off: assert property (!r_q.enable [*4] |-> r_q.ackN)
        else $error("grant driven while release is disabled");

    a_word_hold: assert property (r_q.phase == BRC_OWNED && seq.cycleEnd && seq.upperByte
        && !seq.sleep && !seq.mulDiv |=> r_q.ackN)
        else $error("bus released between the bytes of a word");

    a_two_state: assert property (sTwoSample ##1 sTwoEnd |=> !r_q.ackN && cpuHold)
        else $error("two-state access did not release after second state");

    a_three_state: assert property (r_q.phase == BRC_OWNED && r_q.enable && seq.threeState && seq.stateT1
        && busRequest && !seq.sleep ##[1:20] sThreeEnd |=> !r_q.ackN)
        else $error("three-state access did not release after third state");

    a_internal_op: assert property (r_q.phase == BRC_OWNED && r_q.enable && seq.internalOp && seq.stateT1
        && seq.cycleEnd && busRequest && !hwStandby && resetPin_n |=> !r_q.ackN)
        else $error("internal operation did not release after first state");

    a_muldiv_end: assert property (r_q.phase == BRC_OWNED && r_q.enable && seq.mulDiv && seq.cycleEnd
        && busRequest && !hwStandby && resetPin_n |=> !r_q.ackN)
        else $error("multiply or divide did not release at machine cycle end");

    a_sleep_grant: assert property (r_q.phase == BRC_OWNED && seq.sleep && busRequest
        && !hwStandby && resetPin_n |=> !r_q.ackN)
        else $error("sleep mode did not grant at once");

    a_float_bus: assert property (!r_q.ackN |-> busOe_n && cpuHold)
        else $error("bus driven while granted away");

    a_stay_released: assert property (r_q.phase == BRC_RELEASED && busRequest
        && !hwStandby && resetPin_n |=> r_q.phase == BRC_RELEASED && !r_q.ackN)
        else $error("released state left while request low");

    a_reclaim_time: assert property (r_q.phase == BRC_RELEASED && !busRequest && !hwStandby && resetPin_n
        |=> !r_q.ackN ##1 r_q.ackN)
        else $error("grant did not return high one state after request");

    a_resume_time: assert property ($rose(rIn_q.ackN) && $past(rIn_q.phase) == BRC_RECLAIM
        && !hwStandby && resetPin_n |-> cpuHold ##1 !cpuHold)
        else $error("CPU did not resume one state after grant high");

    a_no_irq: assert property (!r_q.ackN |-> intBlock)
        else $error("interrupts not blocked while released");

    a_pin_reset: assert property ($past(!resetPin_n) |-> r_q.phase == BRC_OWNED && !r_q.enable)
        else $error("reset pin did not reset the block");

    // ------------------------------------------------------------
    // Register and pin assertions
    // ------------------------------------------------------------
    a_rdata_idle: assert property (!$past(regReq.rd) |-> regRdata == BRC_UNMAPPED_DATA)
        else $error("read data not idle outside a read answer");

    a_rdata_unmapped: assert property ($past(regReq.rd && !ctrlHit) |-> regRdata == BRC_UNMAPPED_DATA)
        else $error("unmapped read did not return zero");

    a_rdata_enable: assert property ($past(regReq.rd && ctrlHit && resetPin_n && !hwStandby && rst_n)
        |-> regRdata[BRC_EN_BIT] == $past(r_q.enable))
        else $error("enable bit read back wrong");

    a_write_other: assert property (regReq.wr && !ctrlHit && resetPin_n && !hwStandby
        |=> $stable(r_q.enable))
        else $error("write to another address changed the enable bit");

    a_hold_enable: assert property (!(regReq.wr && ctrlHit) && resetPin_n && !hwStandby
        |=> $stable(r_q.enable))
        else $error("control register changed without a write");

    a_wipe_rdata: assert property (hwStandby |=> regRdata == BRC_UNMAPPED_DATA)
        else $error("read data not cleared by hardware standby");

    a_wipe_state: assert property (!resetPin_n || hwStandby
        |=> r_q.phase == BRC_OWNED && r_q.ackN && !r_q.pend)
        else $error("bus phase not cleared by reset");

    a_wipe_free: assert property (!resetPin_n |=> !cpuHold && !busOe_n)
        else $error("bus not returned to the CPU by reset");

    a_pin5_input: assert property (r_q.enable |-> portA5Oe_n)
        else $error("request pin driven while enabled");

    a_pin6_grant: assert property (r_q.enable |-> !portA6Oe_n && portA6Out == r_q.ackN)
        else $error("grant pin not driven with the grant while enabled");

    a_pin5_off: assert property (!r_q.enable |-> portA5Oe_n == !gpioDrive[BRC_PIN_REQ]
        && portA5Out == gpioOut[BRC_PIN_REQ])
        else $error("port pin 5 not given to GPIO while disabled");

    a_gpio_sample: assert property (resetPin_n && !hwStandby |=> gpioIn == $past({portA6In, portA5In}))
        else $error("port input copy wrong");

    a_grant_mirror: assert property (r_q.enable |-> grantActive == !portA6Out)
        else $error("grant mirror differs from the grant pin");

    // ------------------------------------------------------------
    // Phase assertions
    // ------------------------------------------------------------
    sequence sRelQuit;
        r_q.phase == BRC_RELEASED && !busRequest && resetPin_n && !hwStandby;
    endsequence

    sequence sReclaimStep;
        r_q.phase == BRC_RECLAIM && !r_q.ackN;
    endsequence

    sequence sResumeStep;
        r_q.phase == BRC_RESUME && r_q.ackN;
    endsequence

    a_phase_onehot: assert property ($onehot(r_q.phase))
        else $error("bus phase not one-hot");

    a_held_phase: assert property (r_q.phase != BRC_OWNED |-> cpuHold && intBlock)
        else $error("CPU not held while the bus is away");

    a_owned_free: assert property (r_q.phase == BRC_OWNED |-> !cpuHold && !intBlock && r_q.ackN)
        else $error("CPU held while it owns the bus");

    a_released_ack: assert property (r_q.phase == BRC_RELEASED |-> !r_q.ackN && busOe_n)
        else $error("grant high while released");

    a_reclaim_ack: assert property (r_q.phase == BRC_RECLAIM |-> !r_q.ackN)
        else $error("grant rose too early on reclaim");

    a_resume_ack: assert property (r_q.phase == BRC_RESUME |-> r_q.ackN && cpuHold)
        else $error("grant low or CPU free in resume state");

    a_bus_drive: assert property (r_q.ackN |-> !busOe_n)
        else $error("bus floated while the CPU owns it");

    a_reclaim_path: assert property (sRelQuit |=> sReclaimStep)
        else $error("released state not left after request high");

    a_reclaim_next: assert property (sReclaimStep && resetPin_n && !hwStandby |=> sResumeStep)
        else $error("reclaim state not followed by resume");

    a_resume_next: assert property (sResumeStep && resetPin_n && !hwStandby
        |=> r_q.phase == BRC_OWNED)
        else $error("resume state not followed by CPU ownership");

    a_pend_clear: assert property (r_q.phase != BRC_OWNED |-> !r_q.pend)
        else $error("pending request kept while away");

    a_pend_hold: assert property (r_q.phase == BRC_OWNED && r_q.enable && r_q.pend && !seq.cycleEnd
        && !seq.sleep && resetPin_n && !hwStandby && !(regReq.wr && ctrlHit) |=> r_q.pend)
        else $error("pending request lost before cycle end");

    a_no_early_rel: assert property (r_q.phase == BRC_OWNED && !seq.cycleEnd && !seq.sleep
        |=> r_q.ackN)
        else $error("bus released inside a cycle");

    a_needs_req: assert property (r_q.phase == BRC_OWNED && !r_q.pend && !busRequest
        |=> r_q.ackN)
        else $error("bus released with no request");

    a_off_no_rel: assert property (!r_q.enable [*2] |-> r_q.phase != BRC_RELEASED)
        else $error("released state held while disabled");

    a_off_no_pend: assert property (!r_q.enable [*2] |-> !r_q.pend)
        else $error("request latched while disabled");

    a_grant_fall: assert property ($fell(r_q.ackN) |-> $past(r_q.phase) == BRC_OWNED)
        else $error("grant fell outside CPU ownership");

    a_grant_rise: assert property ($rose(r_q.ackN) && $past(resetPin_n && !hwStandby && rst_n)
        |-> $past(r_q.phase) == BRC_RECLAIM)
        else $error("grant rose outside reclaim");

endmodule

//--- bench/brc_bus_master.sv
// Model of the external master that borrows the bus through request and grant.
`timescale 1ns/10ps
module brc_bus_master
    import brc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic drop,
    input wire logic grant_n,
    output logic req_n
);
    logic [1:0] held_q;
    // The request stays low until the grant is seen low, then one edge more before it rises.
    always_ff @(posedge clk) begin
        if (!rst_n || drop) begin
            req_n <= 1'b1;
            held_q <= 2'h0;
        end else if (go) begin
            req_n <= 1'b0;
            held_q <= 2'h0;
        end else if (!req_n && !grant_n) begin
            held_q <= held_q + 2'h1;
            if (held_q == 2'h1) begin
                req_n <= 1'b1;
            end
        end
    end
endmodule

//--- bench/brc_release_ctrl_tb.sv
// Self-checking bench for the bus release control block.
`timescale 1ns/10ps
module brc_release_ctrl_tb
    import brc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic resetPin_n = 1'b1;
    logic hwStandby = 1'b0;
    logic go = 1'b0;
    logic drop = 1'b0;
    brc_seq_t seq = '0;
    brc_reg_req_t regReq = '0;
    logic [1:0] gpioOut = 2'h0;
    logic [1:0] gpioDrive = 2'h0;
    logic [1:0] gpioIn;
    logic [7:0] regRdata;
    logic portA6Out, portA6Oe_n, portA5Out, portA5Oe_n, busOe_n, cpuHold, intBlock, grantActive, req_n;
    int err_total = 0;
    int num_checks = 0;
    // Pin 6 has a pull-up when not driven; pin 5 sees the master unless the port drives it.
    wire logic portA6In = portA6Oe_n ? 1'b1 : portA6Out;
    wire logic portA5In = portA5Oe_n ? req_n : portA5Out;
    localparam brc_seq_t I0 = '0;
    localparam brc_seq_t A1 = '{twoState: 1'b1, stateT1: 1'b1, default: 1'b0};
    localparam brc_seq_t A2 = '{twoState: 1'b1, stateT2: 1'b1, cycleEnd: 1'b1, default: 1'b0};
    localparam brc_seq_t B1 = '{threeState: 1'b1, stateT1: 1'b1, default: 1'b0};
    localparam brc_seq_t B2 = '{threeState: 1'b1, stateT2: 1'b1, default: 1'b0};
    localparam brc_seq_t BW = '{threeState: 1'b1, stateTw: 1'b1, default: 1'b0};
    localparam brc_seq_t B3 = '{threeState: 1'b1, stateT3: 1'b1, cycleEnd: 1'b1, default: 1'b0};
    localparam brc_seq_t U1 = B1 | 11'h002;
    localparam brc_seq_t U2 = B2 | 11'h002;
    localparam brc_seq_t U3 = B3 | 11'h002;
    localparam brc_seq_t N1 = '{internalOp: 1'b1, stateT1: 1'b1, cycleEnd: 1'b1, default: 1'b0};
    localparam brc_seq_t ME = '{mulDiv: 1'b1, cycleEnd: 1'b1, default: 1'b0};
    localparam brc_seq_t SL = '{sleep: 1'b1, default: 1'b0};

    always #4 clk = ~clk;

    brc_release_ctrl i_brc_release_ctrl (.clk(clk), .rst_n(rst_n), .resetPin_n(resetPin_n),
        .hwStandby(hwStandby), .seq(seq), .regReq(regReq), .regRdata(regRdata), .gpioOut(gpioOut),
        .gpioDrive(gpioDrive), .gpioIn(gpioIn), .portA6In(portA6In), .portA6Out(portA6Out),
        .portA6Oe_n(portA6Oe_n), .portA5In(portA5In), .portA5Out(portA5Out), .portA5Oe_n(portA5Oe_n),
        .busOe_n(busOe_n), .cpuHold(cpuHold), .intBlock(intBlock), .grantActive(grantActive));
    brc_bus_master i_brc_bus_master (.clk(clk), .rst_n(rst_n), .go(go), .drop(drop),
        .grant_n(portA6Out), .req_n(req_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk1(input string nm, input logic e, input logic s);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %0b seen %0b", nm, e, s);
        end
    endtask
    task chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regReq <= '0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        regReq <= '0;
        @(negedge clk);
        chk8("regRdata", e, regRdata);
        @(negedge clk);
        chk8("regRdata idle", 8'h00, regRdata);
    endtask
    // Grant falls, the bus floats and interrupts are held off as one group.
    task rel(input logic e);
        @(negedge clk);
        chk1("grant", ~e, portA6Out);
        chk1("busOe_n", e, busOe_n);
        chk1("cpuHold", e, cpuHold);
        chk1("intBlock", e, intBlock);
        chk1("grantActive", e, grantActive);
    endtask
    task reclaim();
        int k;
        k = 0;
        while (req_n !== 1'b1 && k < 20) begin
            @(negedge clk);
            chk1("grant", 1'b0, portA6Out);
            k++;
        end
        if (k == 20) begin
            err_total++;
            results();
        end
        @(negedge clk);
        chk1("grant", 1'b0, portA6Out);
        @(negedge clk);
        chk1("grant", 1'b1, portA6Out);
        chk1("busOe_n", 1'b0, busOe_n);
        chk1("cpuHold", 1'b1, cpuHold);
        @(negedge clk);
        chk1("cpuHold", 1'b0, cpuHold);
    endtask
    // Each step is one state; a go flag makes the master pull its request low in the next state.
    task run(input brc_seq_t s[6], input logic [5:0] g, input int n, input logic e);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            seq <= s[i];
            go <= g[i];
        end
        rel(e);
        if (e) begin
            reclaim();
        end
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(16'hFF1B, 8'hFE);
        rd(16'hFF1A, 8'h00);
        wr(16'hFF1A, 8'h01);
        rd(16'hFF1B, 8'hFE);
        gpioDrive <= 2'b10;
        gpioOut <= 2'b10;
        run('{I0, A1, A2, I0, I0, I0}, 6'h01, 4, 1'b0);
        chk8("gpioIn", 8'h02, {6'h00, gpioIn});
        chk1("portA5Oe_n", 1'b1, portA5Oe_n);
        @(posedge clk);
        drop <= 1'b1;
        gpioDrive <= 2'b01;
        gpioOut <= 2'b01;
        @(posedge clk);
        drop <= 1'b0;
        @(negedge clk);
        chk1("portA6Oe_n", 1'b1, portA6Oe_n);
        chk1("portA5Out", 1'b1, portA5Out);
        wr(16'hFF1B, 8'h01);
        repeat (2) @(negedge clk);
        chk1("portA6Oe_n", 1'b0, portA6Oe_n);
        chk1("portA5Oe_n", 1'b1, portA5Oe_n);
        chk1("grant", 1'b1, portA6Out);
        run('{I0, A1, A2, I0, I0, I0}, 6'h01, 4, 1'b1);
        run('{B1, B2, BW, B3, I0, I0}, 6'h02, 5, 1'b1);
        run('{I0, U1, U2, U3, I0, I0}, 6'h01, 5, 1'b0);
        run('{B1, B2, B3, I0, I0, I0}, 6'h00, 4, 1'b1);
        run('{I0, N1, I0, I0, I0, I0}, 6'h01, 3, 1'b1);
        run('{I0, ME, I0, I0, I0, I0}, 6'h01, 3, 1'b1);
        run('{SL, SL, SL, I0, I0, I0}, 6'h01, 3, 1'b1);
        for (int i = 0; i < 2; i++) begin
            wr(16'hFF1B, 8'h01);
            rd(16'hFF1B, 8'hFF);
            @(posedge clk);
            resetPin_n <= (i != 0);
            hwStandby <= (i != 0);
            @(posedge clk);
            resetPin_n <= 1'b1;
            hwStandby <= 1'b0;
            rd(16'hFF1B, 8'hFE);
        end
        results();
    end
endmodule
